// File: inc/aux_fault_defs.svh
`ifndef AUX_FAULT_DEFS_SVH
`define AUX_FAULT_DEFS_SVH

// Register indexes; the byte address is four times the index.
`define AUX_IDX_OV_THRESH 10'h028
`define AUX_IDX_OV_HYST 10'h029
`define AUX_IDX_UV_THRESH 10'h02A
`define AUX_IDX_UV_HYST 10'h02B
`define AUX_IDX_SFD_CFG 10'h02C
`define AUX_IDX_FUNC_SEL 10'h02D
`define AUX_IDX_LOGIC_CFG 10'h02E
`define AUX_IDX_IRQ_STATUS 10'h040
`define AUX_IDX_IRQ_MASK 10'h041
`define AUX_IDX_STATE 10'h042

`define AUX_ADDR_W 12
`define AUX_CNT_W 21

// Writable bit masks and reset values.
`define AUX_HYST_MASK 8'h1F
`define AUX_SFD_CFG_MASK 8'h1F
`define AUX_FUNC_SEL_MASK 8'h03
`define AUX_LOGIC_CFG_MASK 8'h7F
`define AUX_REG_RESET 8'h00
`define AUX_FUNC_SEL_RESET 8'h03
`define AUX_IRQ_W 3

// Field positions.
`define AUX_HYST_MSB 4
`define AUX_GF_MSB 4
`define AUX_GF_LSB 2
`define AUX_TYPE_MSB 1
`define AUX_SEL_MSB 1
`define AUX_INVERT_BIT 6
`define AUX_EDGE_BIT 5
`define AUX_PULSE_MSB 4
`define AUX_PULSE_LSB 3
`define AUX_LGF_MSB 2

// Interrupt status bit positions.
`define AUX_IRQ_FAULT 0
`define AUX_IRQ_WARN 1
`define AUX_IRQ_LOGIC 2

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

// Timing.
`define AUX_CLK_PERIOD_NS 5
`define AUX_NS_PER_US 1000
`define AUX_GF_US_0 0
`define AUX_GF_US_1 5
`define AUX_GF_US_2 10
`define AUX_GF_US_3 20
`define AUX_GF_US_4 30
`define AUX_GF_US_5 50
`define AUX_GF_US_6 75
`define AUX_GF_US_7 100
`define AUX_PULSE_US_0 10
`define AUX_PULSE_US_1 100
`define AUX_PULSE_US_2 1000
`define AUX_PULSE_US_3 10000
`define AUX_US_TO_CYC(us) \
  (((us) * `AUX_NS_PER_US + `AUX_CLK_PERIOD_NS - 1) / `AUX_CLK_PERIOD_NS)

`endif

// File: inc/aux_fault_pkg.sv
package aux_fault_pkg;

  typedef enum logic [1:0] {
    TYPE_OVER,
    TYPE_UNDER_OR_OVER,
    TYPE_UNDER,
    TYPE_OFF
  } detector_type_t;

  typedef enum logic [1:0] {
    FUNC_FAULT_ONLY,
    FUNC_LOGIC_ONLY,
    FUNC_LOGIC_AND_WARNING,
    FUNC_NONE
  } function_select_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic out;
    logic [20:0] cnt;
  } filter_state_t;

endpackage : aux_fault_pkg

// File: rtl/aux_input_fault_detector.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "aux_fault_defs.svh"

// Function
// - Overvoltage compare on 8-bit threshold, lowered by 5-bit hysteresis while tripped.
// - Select 10: logic input active and fault detector reports a warning.
// - Select 11: no fault and no logic function on the input.
// - Logic config bit 6 inverts the sensed input before detection.
// - Logic config bit 5: 0 reports level, 1 detects edges.
// - Edge mode emits a 10, 100, 1000 or 10000 us pulse.
// - Pulses shorter than the 3-bit glitch setting are ignored, both filters.
module aux_input_fault_detector
  import aux_fault_pkg::*;
#(
  parameter int unsigned GLITCH_CYC [8] = '{
    `AUX_US_TO_CYC(`AUX_GF_US_0), `AUX_US_TO_CYC(`AUX_GF_US_1),
    `AUX_US_TO_CYC(`AUX_GF_US_2), `AUX_US_TO_CYC(`AUX_GF_US_3),
    `AUX_US_TO_CYC(`AUX_GF_US_4), `AUX_US_TO_CYC(`AUX_GF_US_5),
    `AUX_US_TO_CYC(`AUX_GF_US_6), `AUX_US_TO_CYC(`AUX_GF_US_7)},
  parameter int unsigned PULSE_CYC [4] = '{
    `AUX_US_TO_CYC(`AUX_PULSE_US_0), `AUX_US_TO_CYC(`AUX_PULSE_US_1),
    `AUX_US_TO_CYC(`AUX_PULSE_US_2), `AUX_US_TO_CYC(`AUX_PULSE_US_3)}
) (
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register bus.
  input wire axi_req_t axiReq,
  output axi_rsp_t axiRsp,
  // Auxiliary input: digitised level and logic sense.
  input wire logic [7:0] auxLevel,
  input wire logic auxPin,
  // Results to the sequencing engine.
  output logic fault,
  output logic warning,
  output logic logicOut,
  output logic irq
);

  typedef struct packed {
    logic awHeld;
    logic [11:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ovThresh;
    logic [7:0] ovHyst;
    logic [7:0] uvThresh;
    logic [7:0] uvHyst;
    logic [7:0] sfdCfg;
    logic [7:0] funcSel;
    logic [7:0] logicCfg;
    logic [2:0] status;
    logic [2:0] mask;
    logic ovState;
    logic uvState;
    logic sensedPrev;
    logic [20:0] pulseCnt;
    logic fault;
    logic warning;
    logic logicOut;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic sfdFiltered;
  logic sensedFiltered;

  function automatic logic [9:0] regIndex(input logic [11:0] addr);
    regIndex = addr[11:2];
  endfunction : regIndex

  function automatic logic isMapped(input logic [11:0] addr);
    case (regIndex(addr))
      `AUX_IDX_OV_THRESH, `AUX_IDX_OV_HYST, `AUX_IDX_UV_THRESH,
      `AUX_IDX_UV_HYST, `AUX_IDX_SFD_CFG, `AUX_IDX_FUNC_SEL,
      `AUX_IDX_LOGIC_CFG, `AUX_IDX_IRQ_STATUS, `AUX_IDX_IRQ_MASK,
      `AUX_IDX_STATE: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  function automatic logic [20:0] glitchLimit(input logic [2:0] code);
    glitchLimit = GLITCH_CYC[code][20:0];
  endfunction : glitchLimit

  // Decoded controls.
  function_select_t funcSel;
  detector_type_t detType;
  logic sfdEnable;
  logic logicEnable;
  logic [7:0] ovEff;
  logic [7:0] uvEff;
  logic [8:0] uvSum;
  logic ovRaw;
  logic uvRaw;
  logic sensed;
  logic [20:0] pulseLen;
  logic wrFire;
  logic rdFire;
  logic [7:0] wByte;
  logic [2:0] events;

  always_comb begin
    funcSel = function_select_t'(st.funcSel[`AUX_SEL_MSB:0]);
    detType = detector_type_t'(st.sfdCfg[`AUX_TYPE_MSB:0]);
    sfdEnable = (funcSel == FUNC_FAULT_ONLY) ||
                (funcSel == FUNC_LOGIC_AND_WARNING);
    logicEnable = (funcSel == FUNC_LOGIC_ONLY) ||
                  (funcSel == FUNC_LOGIC_AND_WARNING);
    // The trip point moves only while the comparator is already tripped.
    if (st.ovState && (st.ovThresh >= st.ovHyst)) begin
      ovEff = st.ovThresh - st.ovHyst;
    end else if (st.ovState) begin
      ovEff = 8'h00;
    end else begin
      ovEff = st.ovThresh;
    end
    uvSum = {1'b0, st.uvThresh} + {1'b0, st.uvHyst};
    if (st.uvState) begin
      uvEff = uvSum[8] ? 8'hFF : uvSum[7:0];
    end else begin
      uvEff = st.uvThresh;
    end
    ovRaw = sfdEnable && (auxLevel > ovEff) &&
            ((detType == TYPE_OVER) || (detType == TYPE_UNDER_OR_OVER));
    uvRaw = sfdEnable && (auxLevel < uvEff) &&
            ((detType == TYPE_UNDER) || (detType == TYPE_UNDER_OR_OVER));
    sensed = logicEnable &&
             (auxPin ^ st.logicCfg[`AUX_INVERT_BIT]);
    pulseLen = PULSE_CYC[st.logicCfg[`AUX_PULSE_MSB:`AUX_PULSE_LSB]][20:0];
  end

  glitch_filter sfdFilter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din(st.ovState | st.uvState),
    .limit(glitchLimit(st.sfdCfg[`AUX_GF_MSB:`AUX_GF_LSB])),
    .dout(sfdFiltered)
  );

  glitch_filter logicFilter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din(sensed),
    .limit(glitchLimit(st.logicCfg[`AUX_LGF_MSB:0])),
    .dout(sensedFiltered)
  );

  // Bus handshakes; readies drop while the clock enable is low.
  always_comb begin
    axiRsp.awready = ce && !st.awHeld && !st.bvalid;
    axiRsp.wready = ce && !st.wHeld && !st.bvalid;
    axiRsp.bvalid = st.bvalid;
    axiRsp.bresp = st.bresp;
    axiRsp.arready = ce && !st.rvalid;
    axiRsp.rvalid = st.rvalid;
    axiRsp.rdata = st.rdata;
    axiRsp.rresp = st.rresp;
  end

  always_comb begin
    next_st = st;
    wByte = st.wData[7:0];
    wrFire = 1'b0;
    rdFire = 1'b0;
    events = '0;

    // Write address and data are taken in either order.
    if (axiReq.awvalid && axiRsp.awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
    end
    if (st.bvalid && axiReq.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.bvalid) begin
      wrFire = st.wStrb[0];
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = isMapped(st.awAddr) ? `AXI_RESP_OKAY
                                          : `AXI_RESP_SLVERR;
    end
    if (wrFire) begin
      case (regIndex(st.awAddr))
        `AUX_IDX_OV_THRESH: next_st.ovThresh = wByte;
        `AUX_IDX_OV_HYST: next_st.ovHyst = wByte & `AUX_HYST_MASK;
        `AUX_IDX_UV_THRESH: next_st.uvThresh = wByte;
        `AUX_IDX_UV_HYST: next_st.uvHyst = wByte & `AUX_HYST_MASK;
        `AUX_IDX_SFD_CFG: next_st.sfdCfg = wByte & `AUX_SFD_CFG_MASK;
        `AUX_IDX_FUNC_SEL: next_st.funcSel = wByte & `AUX_FUNC_SEL_MASK;
        `AUX_IDX_LOGIC_CFG: next_st.logicCfg = wByte & `AUX_LOGIC_CFG_MASK;
        `AUX_IDX_IRQ_STATUS: next_st.status = st.status & ~wByte[2:0];
        `AUX_IDX_IRQ_MASK: next_st.mask = wByte[2:0];
        default: next_st.status = next_st.status;
      endcase
    end

    // Read path: one read under way at a time.
    if (st.rvalid && axiReq.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      rdFire = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp = isMapped(axiReq.araddr) ? `AXI_RESP_OKAY
                                              : `AXI_RESP_SLVERR;
      next_st.rdata = '0;
      case (regIndex(axiReq.araddr))
        `AUX_IDX_OV_THRESH: next_st.rdata[7:0] = st.ovThresh;
        `AUX_IDX_OV_HYST: next_st.rdata[7:0] = st.ovHyst;
        `AUX_IDX_UV_THRESH: next_st.rdata[7:0] = st.uvThresh;
        `AUX_IDX_UV_HYST: next_st.rdata[7:0] = st.uvHyst;
        `AUX_IDX_SFD_CFG: next_st.rdata[7:0] = st.sfdCfg;
        `AUX_IDX_FUNC_SEL: next_st.rdata[7:0] = st.funcSel;
        `AUX_IDX_LOGIC_CFG: next_st.rdata[7:0] = st.logicCfg;
        `AUX_IDX_IRQ_STATUS: next_st.rdata[2:0] = st.status;
        `AUX_IDX_IRQ_MASK: next_st.rdata[2:0] = st.mask;
        `AUX_IDX_STATE: next_st.rdata[4:0] = {st.uvState, st.ovState,
          st.logicOut, st.warning, st.fault};
        default: next_st.rdata = '0;
      endcase
    end

    // Comparator state carries the hysteresis.
    next_st.ovState = ovRaw;
    next_st.uvState = uvRaw;

    // Filtered detector result is a fault or, in shared mode, a warning.
    next_st.fault = sfdFiltered && (funcSel == FUNC_FAULT_ONLY);
    next_st.warning = sfdFiltered &&
                      (funcSel == FUNC_LOGIC_AND_WARNING);

    // Logic path: level follows the input, edge mode stretches a pulse.
    next_st.sensedPrev = sensedFiltered;
    if (!logicEnable) begin
      next_st.logicOut = 1'b0;
      next_st.pulseCnt = '0;
    end else if (!st.logicCfg[`AUX_EDGE_BIT]) begin
      next_st.logicOut = sensedFiltered;
      next_st.pulseCnt = '0;
    end else if (sensedFiltered && !st.sensedPrev) begin
      next_st.logicOut = 1'b1;
      next_st.pulseCnt = pulseLen - 21'h000001;
    end else if (st.pulseCnt != '0) begin
      next_st.pulseCnt = st.pulseCnt - 21'h000001;
    end else begin
      next_st.logicOut = 1'b0;
    end

    // Rising outputs set sticky status bits; a set beats a clear.
    events[`AUX_IRQ_FAULT] = next_st.fault && !st.fault;
    events[`AUX_IRQ_WARN] = next_st.warning && !st.warning;
    events[`AUX_IRQ_LOGIC] = next_st.logicOut && !st.logicOut;
    next_st.status = next_st.status | events;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.funcSel <= `AUX_FUNC_SEL_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign fault = st.fault;
  assign warning = st.warning;
  assign logicOut = st.logicOut;
  assign irq = |(st.status & st.mask);

endmodule : aux_input_fault_detector

// File: rtl/glitch_filter.sv
`timescale 1ns/10ps
`include "aux_fault_defs.svh"

module glitch_filter
  import aux_fault_pkg::*;
(
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Filter path.
  input wire logic din,
  input wire logic [`AUX_CNT_W-1:0] limit,
  output logic dout
);

  filter_state_t st;
  filter_state_t next_st;

  // A new level must hold for more than limit cycles to pass.
  always_comb begin
    next_st = st;
    if (din == st.out) begin
      next_st.cnt = '0;
    end else if (st.cnt >= limit) begin
      next_st.out = din;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 21'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign dout = st.out;

endmodule : glitch_filter

// File: test/aux_input_fault_detector_checker.sv
`timescale 1ns/10ps
module aux_input_fault_detector_checker
  import aux_fault_pkg::*;
(
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register bus.
  input wire axi_req_t axiReq,
  input wire axi_rsp_t axiRsp,
  // Input and results.
  input wire logic [7:0] auxLevel,
  input wire logic auxPin,
  input wire logic fault,
  input wire logic warning,
  input wire logic logicOut,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence rdTake;
    axiReq.arvalid && axiRsp.arready && ce;
  endsequence
  sequence wrTake;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready && ce;
  endsequence

  chk_read_answer: assert property (rdTake |=> axiRsp.rvalid)
    else $error("read answer missing");
  chk_write_answer: assert property (wrTake |-> ##[1:2] axiRsp.bvalid)
    else $error("write answer missing");
  chk_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready
    |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  chk_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready
    |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  chk_ar_block: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read taken while answer pending");
  chk_aw_block: assert property (axiRsp.bvalid
    |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while answer pending");
  chk_fault_excl: assert property (!(fault && warning))
    else $error("fault and warning together");
  chk_reset_quiet: assert property (disable iff (1'b0) reset
    |=> !fault && !warning && !logicOut && !irq)
    else $error("outputs active after reset");
endmodule : aux_input_fault_detector_checker

bind aux_input_fault_detector aux_input_fault_detector_checker chk (
  .clk, .reset, .ce, .axiReq, .axiRsp, .auxLevel, .auxPin,
  .fault, .warning, .logicOut, .irq
);

// File: test/tb_aux_input_fault_detector.sv
`timescale 1ns/10ps
`include "aux_fault_defs.svh"
module tb_aux_input_fault_detector
  import aux_fault_pkg::*;
;
  localparam int unsigned PC [4] = '{3, 5, 7, 9};
  logic clk, reset, ce, auxPin, fault, warning, logicOut, irq;
  logic [7:0] auxLevel;
  axi_req_t q;
  axi_rsp_t rs;
  logic [31:0] rdat;
  logic [1:0] resp;
  int badCount, checksDone;

  aux_input_fault_detector #(
    .GLITCH_CYC('{0, 2, 3, 4, 5, 6, 7, 8}),
    .PULSE_CYC(PC)
  ) DUT (
    .clk, .reset, .ce, .axiReq(q), .axiRsp(rs), .auxLevel, .auxPin,
    .fault, .warning, .logicOut, .irq
  );

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    q.awvalid <= 1;
    q.awaddr <= {i, 2'h0};
    q.wvalid <= 1;
    q.wdata <= {24'h0, d};
    q.wstrb <= 4'hF;
    q.bready <= 1;
    do @(posedge clk); while (!(rs.awready && rs.wready));
    q.awvalid <= 0;
    q.wvalid <= 0;
    do @(posedge clk); while (!rs.bvalid);
    q.bready <= 0;
  endtask : wr

  task automatic rd(input logic [9:0] i);
    @(posedge clk);
    q.arvalid <= 1;
    q.araddr <= {i, 2'h0};
    q.rready <= 1;
    do @(posedge clk); while (!rs.arready);
    q.arvalid <= 0;
    do @(posedge clk); while (!rs.rvalid);
    rdat = rs.rdata;
    resp = rs.rresp;
    q.rready <= 0;
  endtask : rd

  // Applies a level and checks the settled {warning, fault} pair.
  task automatic lv(input logic [7:0] v, input logic [1:0] e);
    auxLevel <= v;
    wt(8);
    chk({warning, fault}, e);
  endtask : lv

  task automatic endSim;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : endSim

  task automatic tRegs;
    rd(`AUX_IDX_FUNC_SEL);
    chk(rdat, 32'h3);
    wr(`AUX_IDX_OV_HYST, 8'hFF);
    rd(`AUX_IDX_OV_HYST);
    chk(rdat, 32'h1F);
    rd(10'h3FF);
    chk(resp, `AXI_RESP_SLVERR);
    $display("registers done");
  endtask : tRegs

  task automatic tOver;
    wr(`AUX_IDX_FUNC_SEL, 8'h00);
    wr(`AUX_IDX_SFD_CFG, 8'h00);
    wr(`AUX_IDX_OV_THRESH, 8'h64);
    wr(`AUX_IDX_OV_HYST, 8'h0A);
    lv(8'h64, 2'h0);
    lv(8'h65, 2'h1);
    lv(8'h5B, 2'h1);
    lv(8'h5A, 2'h0);
    lv(8'h5B, 2'h0);
    wr(`AUX_IDX_SFD_CFG, 8'h1C);
    auxLevel <= 8'h65;
    wt(5);
    lv(8'h00, 2'h0);
    auxLevel <= 8'h65;
    wt(14);
    chk(fault, 1'b1);
    // A low clock enable freezes the trip and drops the bus readies.
    ce <= 0;
    auxLevel <= 8'h00;
    wt(14);
    chk(fault, 1'b1);
    chk(rs.awready, 1'b0);
    chk(rs.arready, 1'b0);
    ce <= 1;
    wt(14);
    chk(fault, 1'b0);
    $display("overvoltage done");
  endtask : tOver

  task automatic tUnder;
    wr(`AUX_IDX_SFD_CFG, 8'h02);
    wr(`AUX_IDX_UV_THRESH, 8'h32);
    wr(`AUX_IDX_UV_HYST, 8'h05);
    lv(8'h28, 2'h1);
    lv(8'h34, 2'h1);
    lv(8'h3C, 2'h0);
    lv(8'h34, 2'h0);
    wr(`AUX_IDX_SFD_CFG, 8'h01);
    lv(8'h28, 2'h1);
    lv(8'h46, 2'h0);
    lv(8'h78, 2'h1);
    wr(`AUX_IDX_SFD_CFG, 8'h03);
    lv(8'h78, 2'h0);
    $display("undervoltage done");
  endtask : tUnder

  task automatic tModes;
    wr(`AUX_IDX_SFD_CFG, 8'h00);
    wr(`AUX_IDX_LOGIC_CFG, 8'h00);
    wr(`AUX_IDX_FUNC_SEL, 8'h02);
    auxPin <= 1;
    lv(8'h65, 2'h2);
    chk(logicOut, 1'b1);
    wr(`AUX_IDX_FUNC_SEL, 8'h03);
    lv(8'h65, 2'h0);
    chk(logicOut, 1'b0);
    $display("function select done");
  endtask : tModes

  task automatic tLogic;
    int n;
    int k;
    wr(`AUX_IDX_FUNC_SEL, 8'h01);
    wr(`AUX_IDX_LOGIC_CFG, 8'h40);
    auxPin <= 0;
    wt(6);
    chk(logicOut, 1'b1);
    auxPin <= 1;
    wt(6);
    chk(logicOut, 1'b0);
    wr(`AUX_IDX_LOGIC_CFG, 8'h07);
    wt(14);
    auxPin <= 0;
    wt(4);
    auxPin <= 1;
    wt(4);
    chk(logicOut, 1'b1);
    for (int c = 0; c < 4; c++) begin
      auxPin <= 0;
      wr(`AUX_IDX_LOGIC_CFG, {3'h1, c[1:0], 3'h0});
      wt(12);
      auxPin <= 1;
      n = 0;
      k = 0;
      while (logicOut !== 1'b1 && k < 40) begin
        @(posedge clk);
        k++;
      end
      while (logicOut === 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      chk(n, PC[c]);
    end
    $display("logic input done");
  endtask : tLogic

  task automatic tIrq;
    wr(`AUX_IDX_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    rd(`AUX_IDX_IRQ_STATUS);
    chk(rdat[2], 1'b1);
    wr(`AUX_IDX_IRQ_MASK, 8'h04);
    chk(irq, 1'b1);
    wr(`AUX_IDX_IRQ_STATUS, 8'h04);
    rd(`AUX_IDX_IRQ_STATUS);
    chk(rdat[2], 1'b0);
    chk(irq, 1'b0);
    $display("interrupt done");
  endtask : tIrq

  initial begin
    q = '0;
    auxLevel = 8'h00;
    auxPin = 0;
    reset = 1;
    ce = 1;
    badCount = 0;
    checksDone = 0;
    wt(16);
    reset <= 0;
    tRegs;
    tOver;
    tUnder;
    tModes;
    tLogic;
    tIrq;
    endSim;
  end

  initial begin
    wt(20000);
    badCount++;
    $display("[ERR] %0t run did not finish", $time);
    endSim;
  end
endmodule : tb_aux_input_fault_detector
